/* File: include/dcut_defs.vh */
/*
 * Constants for the dual-channel serial block with timer:
 * register offsets, field positions, reset values, codes and rates.
 * Included by rtl/dcut_top.v and by the checker and bench; definitions only.
 */
`ifndef DCUT_DEFS_VH
`define DCUT_DEFS_VH

// register byte offsets on the apb bus
`define DCUT_OFS_MODE0 8'h00
`define DCUT_OFS_DATA0 8'h04
`define DCUT_OFS_STAT0 8'h08
`define DCUT_OFS_MODE1 8'h10
`define DCUT_OFS_DATA1 8'h14
`define DCUT_OFS_STAT1 8'h18
`define DCUT_OFS_TPRE 8'h20
`define DCUT_OFS_TDUTY 8'h24
`define DCUT_OFS_TCTL 8'h28
`define DCUT_OFS_TCNT 8'h2C
`define DCUT_OFS_ISTAT 8'h30
`define DCUT_OFS_IEN 8'h34
`define DCUT_OFS_ICLR 8'h38

// channel mode register fields
`define DCUT_M_LEN 1:0
`define DCUT_M_PAR 3:2
`define DCUT_M_STOP 8:4
`define DCUT_M_LOOP 10:9
`define DCUT_M_MDROP 11
`define DCUT_M_RXCS 15:12
`define DCUT_M_TXCS 19:16
`define DCUT_M_RTS 20
`define DCUT_M_CTSEN 21
`define DCUT_M_ADBIT 22
`define DCUT_M_TXEN 23
`define DCUT_M_RXEN 24
`define DCUT_MODE_W 25
`define DCUT_MODE_RST 25'h0000000

// parity and loop codes
`define DCUT_PAR_NONE 2'h0
`define DCUT_PAR_EVEN 2'h1
`define DCUT_PAR_ODD 2'h2
`define DCUT_LOOP_NORM 2'h0
`define DCUT_LOOP_ECHO 2'h1
`define DCUT_LOOP_LOCAL 2'h2
`define DCUT_LOOP_REMOTE 2'h3

// timer control fields, interrupt width
`define DCUT_T_MODE 0
`define DCUT_T_RUN 1
`define DCUT_IRQ_W 11
`define DCUT_IRQ_TMR 10

// queue depths, bit phases (sixteenths of a bit)
`define DCUT_TXQ_FULL 2'h2
`define DCUT_RXQ_FULL 3'h4
`define DCUT_PH_MID 4'h7
`define DCUT_PH_LAST 4'hF

// rates: 100 MHz system clock, 3.6864 MHz reference, x16 divide 6
`define DCUT_CLK_HZ 28'h5F5E100
`define DCUT_REF_HZ 28'h0384000
`define DCUT_BRG_LAST 3'h5

`endif

/* File: rtl/dcut_top.v */
/*
 * Dual-channel asynchronous serial block with a 16-bit timer/counter,
 * reached as an apb slave (zero wait states).
 * Assumes a 100 MHz clock_i, synchronous active-low reset, and serial
 * and modem inputs already synchronous to clock_i.
 *
 * // Function
 * // two full-duplex channels, each fully independent of the other
 * // character length of five to eight data bits per channel
 * // even, odd or no parity, added on send and checked on receive
 * // stop period up to two bits in sixteenth-bit steps
 * // four-character receive queue and two-character send queue
 * // receive errors raise interrupts, each source maskable
 * // normal, auto echo, local loopback and remote loopback modes
 * // multidrop mode: ninth bit marks address or data characters
 * // standard rates up to 38400 baud from a 3.6864 MHz reference
 * // receiver and transmitter each pick their own rate
 * // per-channel request-to-send output, clear-to-send input
 * // 16-bit timer/counter with counter and timer modes
 * // timer mode: baud source, periodic interrupt, pwm square
 * // counter mode counts down once and interrupts once
 * // low start, data lsb first, optional parity, high stop
 */
`timescale 1ns/1ps
`include "dcut_defs.vh"

module dcut_top (
  input wire clock_i,
  input wire nrst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  output reg [31:0] prdata_o,
  output wire pready_o,
  output wire pslverr_o,
  input wire [1:0] rxd_i,
  output wire [1:0] txd_o,
  input wire [1:0] cts_i,
  output wire [1:0] rts_o,
  output reg tmr_sq_o,
  output wire irq_o
);

localparam TX_IDLE = 3'h0;
localparam TX_START = 3'h1;
localparam TX_DATA = 3'h2;
localparam TX_PAR = 3'h3;
localparam TX_STOP = 3'h4;
localparam RX_IDLE = 2'h0;
localparam RX_START = 2'h1;
localparam RX_BITS = 2'h2;
localparam RX_STOP = 2'h3;

wire acc = psel_i & penable_i;
wire wr = acc & pwrite_i;
wire rd = acc & ~pwrite_i;
reg bad;
reg [31:0] rd_val;
wire [2*`DCUT_MODE_W-1:0] mode_all;
wire [17:0] data_all;
wire [11:0] stat_all;
wire [9:0] ch_evt;

// zero wait states keep the master simple; bad address gives slverr
assign pready_o = 1'b1;
assign pslverr_o = acc & bad;

// reference tick: fractional accumulator, 3.6864 MHz average rate
reg [27:0] racc;
reg ref_tk;
wire [27:0] racc_sum = racc + `DCUT_REF_HZ;
always @(posedge clock_i)
begin
  if (!nrst_i)
  begin
    racc <= 28'h0000000;
    ref_tk <= 1'b0;
  end
  else if (racc_sum >= `DCUT_CLK_HZ)
  begin
    racc <= racc_sum - `DCUT_CLK_HZ;
    ref_tk <= 1'b1;
  end
  else
  begin
    racc <= racc_sum;
    ref_tk <= 1'b0;
  end
end

// rate generator: x16 ticks for 38400 down to 300 baud
reg [2:0] bdiv6;
reg [6:0] bdiv;
wire w6 = ref_tk & (bdiv6 == `DCUT_BRG_LAST);
wire [7:0] rate_tk;
always @(posedge clock_i)
begin
  if (!nrst_i)
  begin
    bdiv6 <= 3'h0;
    bdiv <= 7'h00;
  end
  else if (ref_tk)
  begin
    bdiv6 <= w6 ? 3'h0 : bdiv6 + 3'h1;
    if (w6)
      bdiv <= bdiv + 7'h01;
  end
end
assign rate_tk[0] = w6;
genvar n;
generate
  for (n = 1; n < 8; n = n + 1)
  begin : g_rate
    assign rate_tk[n] = w6 & (&bdiv[n-1:0]);
  end
endgenerate

// timer/counter; counts reference ticks
reg [15:0] tpre;
reg [15:0] tduty;
reg [1:0] tctl;
reg [15:0] tcnt;
wire t_run = tctl[`DCUT_T_RUN];
wire t_tmode = tctl[`DCUT_T_MODE];
wire t_zero = t_run & ref_tk & (tcnt == 16'h0000);
wire tmr_tk = t_zero & t_tmode;
always @(posedge clock_i)
begin
  if (!nrst_i)
  begin
    tpre <= 16'hFFFF;
    tduty <= 16'h0000;
    tctl <= 2'h0;
    tcnt <= 16'h0000;
    tmr_sq_o <= 1'b0;
  end
  else
  begin
    if (wr && paddr_i == `DCUT_OFS_TPRE)
      tpre <= pwdata_i[15:0];
    if (wr && paddr_i == `DCUT_OFS_TDUTY)
      tduty <= pwdata_i[15:0];
    // a control write restarts from the preload
    if (wr && paddr_i == `DCUT_OFS_TCTL)
    begin
      tctl <= pwdata_i[1:0];
      tcnt <= tpre;
    end
    else if (t_zero)
    begin
      tcnt <= tpre;
      if (!t_tmode)
        tctl[`DCUT_T_RUN] <= 1'b0;
    end
    else if (t_run && ref_tk)
      tcnt <= tcnt - 16'h0001;
    tmr_sq_o <= t_run & t_tmode & (tcnt < tduty);
  end
end

// one channel per loop pass, no shared state between them
genvar c;
generate
  for (c = 0; c < 2; c = c + 1)
  begin : g_ch
    reg [`DCUT_MODE_W-1:0] mode;
    reg [8:0] tq [0:1];
    reg [8:0] rq [0:3];
    reg twp, trp, txd, tline, tnin;
    reg [1:0] tcnt_q, rwp, rrp, rst;
    reg [2:0] rcnt, tst;
    reg [4:0] tph;
    reg [3:0] tbit, rph, rbit;
    reg [7:0] tsh;
    reg [8:0] rsh;
    wire [7:0] o_md = c ? `DCUT_OFS_MODE1 : `DCUT_OFS_MODE0;
    wire [7:0] o_dt = c ? `DCUT_OFS_DATA1 : `DCUT_OFS_DATA0;
    wire [1:0] len = mode[`DCUT_M_LEN];
    wire [1:0] par = mode[`DCUT_M_PAR];
    wire [1:0] loop = mode[`DCUT_M_LOOP];
    wire mdrop = mode[`DCUT_M_MDROP];
    wire [3:0] rxcs = mode[`DCUT_M_RXCS];
    wire [3:0] txcs = mode[`DCUT_M_TXCS];
    wire [7:0] mask = 8'hFF >> (2'h3 - len);
    wire [3:0] nb = 4'h5 + {2'h0, len};
    wire has9 = mdrop | (par != `DCUT_PAR_NONE);
    wire [3:0] tot = nb + {3'h0, has9};
    // rate select: codes 8..15 take the timer, else the generator
    wire rx_tk = mode[`DCUT_M_RXEN] &
      (rxcs[3] ? tmr_tk : rate_tk[rxcs[2:0]]);
    wire tx_tk = txcs[3] ? tmr_tk : rate_tk[txcs[2:0]];
    wire [7:0] thd = tq[trp][7:0] & mask;
    wire tpar = (par == `DCUT_PAR_ODD) ? ~^thd : ^thd;
    wire tgo = tx_tk & (tst == TX_IDLE) & (tcnt_q != 2'h0) &
      mode[`DCUT_M_TXEN] &
      (~mode[`DCUT_M_CTSEN] | cts_i[c]);
    wire tph_end = tph[3:0] == `DCUT_PH_LAST;
    wire tdone = tx_tk & (tst == TX_STOP) &
      (tph == mode[`DCUT_M_STOP]);
    wire tpush = wr & (paddr_i == o_dt) & (tcnt_q != `DCUT_TXQ_FULL);
    // receive line per loop mode; remote loop hides the line
    wire rin = (loop == `DCUT_LOOP_LOCAL) ? tline :
      (loop == `DCUT_LOOP_REMOTE) ? 1'b1 : rxd_i[c];
    wire [8:0] al = rsh >> (4'h9 - tot);
    wire [7:0] rdat = al[7:0] & mask;
    wire ninb = al[nb];
    wire rpar = (par == `DCUT_PAR_ODD) ? ~^rdat : ^rdat;
    wire rend = rx_tk & (rst == RX_STOP) & (rph == `DCUT_PH_LAST);
    wire ovr = rend & (rcnt == `DCUT_RXQ_FULL);
    wire pe = rend & ~mdrop & (par != `DCUT_PAR_NONE) &
      (ninb != rpar);
    wire fe = rend & ~rin;
    wire rpop = rd & (paddr_i == o_dt) & (rcnt != 3'h0);

    // mode register and both queues
    always @(posedge clock_i)
    begin
      if (!nrst_i)
      begin
        mode <= `DCUT_MODE_RST;
        twp <= 1'b0;
        trp <= 1'b0;
        tcnt_q <= 2'h0;
        rwp <= 2'h0;
        rrp <= 2'h0;
        rcnt <= 3'h0;
      end
      else
      begin
        if (wr && paddr_i == o_md)
          mode <= pwdata_i[`DCUT_MODE_W-1:0];
        if (tpush)
        begin
          tq[twp] <= {mode[`DCUT_M_ADBIT], pwdata_i[7:0]};
          twp <= ~twp;
        end
        if (tgo)
          trp <= ~trp;
        tcnt_q <= tcnt_q + {1'b0, tpush} - {1'b0, tgo};
        // a full queue drops the new character, flagged as overrun
        if (rend && !ovr)
        begin
          rq[rwp] <= {mdrop & ninb, rdat};
          rwp <= rwp + 2'h1;
        end
        if (rpop)
          rrp <= rrp + 2'h1;
        rcnt <= rcnt + {2'h0, rend & ~ovr} - {2'h0, rpop};
      end
    end

    // transmitter, stepped on its x16 tick
    always @(posedge clock_i)
    begin
      if (!nrst_i)
      begin
        tst <= TX_IDLE;
        tline <= 1'b1;
        txd <= 1'b1;
        tph <= 5'h00;
        tbit <= 4'h0;
        tsh <= 8'h00;
        tnin <= 1'b0;
      end
      else
      begin
        if (tgo)
        begin
          tsh <= thd;
          tnin <= mdrop ? tq[trp][8] : tpar;
          tline <= 1'b0;
          tph <= 5'h00;
          tst <= TX_START;
        end
        else if (tx_tk && tst != TX_IDLE)
        begin
          tph <= (tph_end && tst != TX_STOP) ? 5'h00 : tph + 5'h01;
          case (tst)
            TX_START:
              if (tph_end)
              begin
                tline <= tsh[0];
                tbit <= 4'h0;
                tst <= TX_DATA;
              end
            TX_DATA:
              if (tph_end && tbit == nb - 4'h1)
              begin
                tline <= has9 ? tnin : 1'b1;
                tst <= has9 ? TX_PAR : TX_STOP;
              end
              else if (tph_end)
              begin
                tsh <= tsh >> 1;
                tline <= tsh[1];
                tbit <= tbit + 4'h1;
              end
            TX_PAR:
              if (tph_end)
              begin
                tline <= 1'b1;
                tst <= TX_STOP;
              end
            TX_STOP:
              if (tdone)
                tst <= TX_IDLE;
            default:
              tst <= TX_IDLE;
          endcase
        end
        // echo and remote loop send the line back, mark in local loop
        case (loop)
          `DCUT_LOOP_NORM: txd <= tline;
          `DCUT_LOOP_LOCAL: txd <= 1'b1;
          default: txd <= rxd_i[c];
        endcase
      end
    end

    // receiver: start checked at half bit, then sampled at mid-bit
    always @(posedge clock_i)
    begin
      if (!nrst_i)
      begin
        rst <= RX_IDLE;
        rph <= 4'h0;
        rbit <= 4'h0;
        rsh <= 9'h000;
      end
      else if (rx_tk)
      begin
        rph <= rph + 4'h1;
        case (rst)
          RX_IDLE:
          begin
            rph <= 4'h0;
            if (!rin)
              rst <= RX_START;
          end
          RX_START:
            if (rph == `DCUT_PH_MID)
            begin
              rph <= 4'h0;
              rbit <= 4'h0;
              rst <= rin ? RX_IDLE : RX_BITS; // noise rejects start
            end
          RX_BITS:
            if (rph == `DCUT_PH_LAST)
            begin
              rsh <= {rin, rsh[8:1]};
              rbit <= rbit + 4'h1;
              if (rbit == tot - 4'h1)
                rst <= RX_STOP;
            end
          RX_STOP:
            if (rph == `DCUT_PH_LAST)
              rst <= RX_IDLE;
          default:
            rst <= RX_IDLE;
        endcase
      end
    end

    assign txd_o[c] = txd;
    assign rts_o[c] = mode[`DCUT_M_RTS];
    assign mode_all[c*`DCUT_MODE_W +: `DCUT_MODE_W] = mode;
    assign data_all[c*9 +: 9] = rq[rrp];
    assign stat_all[c*6 +: 6] = {tst == TX_IDLE, tcnt_q, rcnt};
    assign ch_evt[c*5 +: 5] = {fe, pe, ovr, tdone, rend};
  end
endgenerate

// sticky interrupt status; a new event wins over a clear
reg [`DCUT_IRQ_W-1:0] istat;
reg [`DCUT_IRQ_W-1:0] ien;
wire [`DCUT_IRQ_W-1:0] evt = {t_zero, ch_evt};
wire [`DCUT_IRQ_W-1:0] iclr =
  (wr && paddr_i == `DCUT_OFS_ICLR) ? pwdata_i[`DCUT_IRQ_W-1:0] :
  {`DCUT_IRQ_W{1'b0}};
always @(posedge clock_i)
begin
  if (!nrst_i)
  begin
    istat <= {`DCUT_IRQ_W{1'b0}};
    ien <= {`DCUT_IRQ_W{1'b0}};
  end
  else
  begin
    istat <= (istat & ~iclr) | evt;
    if (wr && paddr_i == `DCUT_OFS_IEN)
      ien <= pwdata_i[`DCUT_IRQ_W-1:0];
  end
end
assign irq_o = |(istat & ien);

// read decode; data is captured in the setup cycle
always @*
begin
  bad = 1'b0;
  rd_val = 32'h00000000;
  case (paddr_i)
    `DCUT_OFS_MODE0: rd_val = {7'h00, mode_all[24:0]};
    `DCUT_OFS_MODE1: rd_val = {7'h00, mode_all[49:25]};
    `DCUT_OFS_DATA0: rd_val = {23'h000000, data_all[8:0]};
    `DCUT_OFS_DATA1: rd_val = {23'h000000, data_all[17:9]};
    `DCUT_OFS_STAT0: rd_val = {26'h0000000, stat_all[5:0]};
    `DCUT_OFS_STAT1: rd_val = {26'h0000000, stat_all[11:6]};
    `DCUT_OFS_TPRE: rd_val = {16'h0000, tpre};
    `DCUT_OFS_TDUTY: rd_val = {16'h0000, tduty};
    `DCUT_OFS_TCTL: rd_val = {30'h00000000, tctl};
    `DCUT_OFS_TCNT: rd_val = {16'h0000, tcnt};
    `DCUT_OFS_ISTAT: rd_val = {21'h000000, istat};
    `DCUT_OFS_IEN: rd_val = {21'h000000, ien};
    `DCUT_OFS_ICLR: rd_val = 32'h00000000; // write-only
    default: bad = 1'b1;
  endcase
end

always @(posedge clock_i)
begin
  if (!nrst_i)
    prdata_o <= 32'h00000000;
  else if (psel_i && !penable_i)
    prdata_o <= rd_val;
end

endmodule // dcut_top

/* File: verification/dcut_remote.sv */
/*
 * Remote terminal model for one serial channel: sends frames on line_o
 * and captures frames seen on line_i.
 * Assumes both ends agree on bit time, length and parity.
 */
`timescale 1ns/1ps
module dcut_remote #(
  parameter integer TXB = 2604,
  parameter integer RXB = 2604,
  parameter integer NB = 6
) (
  input wire clock_i,
  input wire line_i,
  output reg line_o
);
  reg [9:0] got [0:3];
  integer got_n = 0;
  integer i;
  // idle mark: the line rests at its pull-up level between frames
  initial line_o = 1'b1;
  // start bit, n bits lsb first, one stop bit
  task send(input [9:0] bits, input integer n);
    integer j;
    begin
      line_o <= 1'b0;
      repeat (TXB) @(posedge clock_i);
      for (j = 0; j < n; j = j + 1)
      begin
        line_o <= bits[j];
        repeat (TXB) @(posedge clock_i);
      end
      line_o <= 1'b1;
      repeat (TXB) @(posedge clock_i);
    end
  endtask
  // mid-bit capture on the falling clock, away from line updates
  initial
  begin
    forever
    begin
      @(negedge line_i);
      // clear the slot so unused upper bits compare as zero
      if (got_n < 4)
        got[got_n] = 10'h000;
      repeat (RXB / 2) @(negedge clock_i);
      for (i = 0; i <= NB; i = i + 1)
      begin
        repeat (RXB) @(negedge clock_i);
        if (got_n < 4)
          got[got_n][i] = line_i; // last bit kept is the stop level
      end
      got_n = got_n + 1;
    end
  end
endmodule // dcut_remote

/* File: verification/dcut_top_sva.sv */
/*
 * Port-level checker for dcut_top, bound to every instance.
 * Assumes the zero-wait apb slave and byte offsets of dcut_defs.vh.
 */
`timescale 1ns/1ps
`include "dcut_defs.vh"
module dcut_top_sva (
  input wire clock_i,
  input wire nrst_i,
  input wire psel_i,
  input wire penable_i,
  input wire pwrite_i,
  input wire [7:0] paddr_i,
  input wire [31:0] pwdata_i,
  input wire [31:0] prdata_o,
  input wire pready_o,
  input wire pslverr_o,
  input wire [1:0] rxd_i,
  input wire [1:0] txd_o,
  input wire [1:0] cts_i,
  input wire [1:0] rts_o,
  input wire tmr_sq_o,
  input wire irq_o
);
  default clocking cb @(posedge clock_i); endclocking
  default disable iff (!nrst_i);
  // decode: holes at 0x0C, 0x1C and above 0x38
  wire acc = psel_i && penable_i;
  wire wr = acc && pwrite_i;
  wire hole = !paddr_i[5] && (paddr_i[3:2] == 2'h3);
  wire mapped = (paddr_i[1:0] == 2'h0) && (paddr_i < 8'h3C) && !hole;
  sequence s_unmap_rd;
    psel_i && !penable_i && !pwrite_i && !mapped;
  endsequence
  reset_idle_a: assert property (disable iff (1'b0) !nrst_i |=>
    txd_o == 2'h3 && rts_o == 2'h0 && !irq_o && !tmr_sq_o)
    else $error("outputs not idle after reset");
  pready_high_a: assert property (acc |-> pready_o)
    else $error("pready low in access phase");
  slverr_unmap_a: assert property (acc && !mapped |-> pslverr_o)
    else $error("unmapped access without error");
  slverr_map_a: assert property (pslverr_o |-> acc && !mapped)
    else $error("error flag without unmapped access");
  unmap_rdzero_a: assert property (s_unmap_rd |=> prdata_o == 32'h0)
    else $error("unmapped read data not zero");
  ien_mask_a: assert property (wr && paddr_i == `DCUT_OFS_IEN &&
    pwdata_i[10:0] == 11'h0 |=> !irq_o)
    else $error("irq high with all sources masked");
  tmr_stop_a: assert property (wr && paddr_i == `DCUT_OFS_TCTL &&
    !pwdata_i[1] |-> ##2 !tmr_sq_o)
    else $error("square output high after timer stop");
  genvar c;
  generate
    for (c = 0; c < 2; c = c + 1)
    begin : g_ch
      reg [11:0] low_run;
      // cycles the line has been low; saturates at 4095, far above the 400 limit
      always @(posedge clock_i)
      begin
        if (!nrst_i || txd_o[c])
          low_run <= 12'h000;
        else if (low_run != 12'hFFF)
          low_run <= low_run + 12'h001;
      end
      sequence s_mode_wr;
        wr && paddr_i == (`DCUT_OFS_MODE0 + 8'h10 * c);
      endsequence
      txd_start_a: assert property ($rose(txd_o[c]) |->
        low_run >= 400)
        else $error("serial low pulse shorter than a bit");
      rts_follow_a: assert property (s_mode_wr |=>
        rts_o[c] == $past(pwdata_i[20]))
        else $error("rts does not follow mode write");
      rts_hold_a: assert property (!$stable(rts_o[c]) |->
        $past(wr && paddr_i == (`DCUT_OFS_MODE0 + 8'h10 * c)))
        else $error("rts changed without mode write");
    end
  endgenerate
endmodule // dcut_top_sva

bind dcut_top dcut_top_sva u_sva (.clock_i(clock_i), .nrst_i(nrst_i),
  .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .rxd_i(rxd_i),
  .txd_o(txd_o), .cts_i(cts_i), .rts_o(rts_o), .tmr_sq_o(tmr_sq_o),
  .irq_o(irq_o));

/* File: verification/dcut_top_test.sv */
/*
 * Self-checking bench for dcut_top: apb tasks, two remote terminals,
 * serial and timer scenarios.
 * Assumes the checker bound and dcut_remote compiled alongside.
 */
`timescale 1ns/1ps
`include "dcut_defs.vh"
module dcut_top_test;
  reg clock_i = 1'b0;
  reg nrst_i = 1'b0;
  reg psel_i = 1'b0;
  reg penable_i = 1'b0;
  reg pwrite_i = 1'b0;
  reg [7:0] paddr_i = 8'h00;
  reg [31:0] pwdata_i = 32'h0;
  reg [1:0] cts_i = 2'h0;
  wire [31:0] prdata_o;
  wire pready_o;
  wire pslverr_o;
  wire [1:0] rxd_i;
  wire [1:0] txd_o;
  wire [1:0] rts_o;
  wire tmr_sq_o;
  wire irq_o;
  reg [31:0] rdata;
  reg rerr;
  integer mismatches = 0;
  integer comparisons = 0;
  integer i;
  integer n;
  dcut_top u_dut (.clock_i(clock_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i),
    .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
    .pslverr_o(pslverr_o), .rxd_i(rxd_i), .txd_o(txd_o), .cts_i(cts_i),
    .rts_o(rts_o), .tmr_sq_o(tmr_sq_o), .irq_o(irq_o));
  // ch0 terminal at 38400 baud, ch1 sends at 19200 and listens at 38400
  dcut_remote #(.NB(9)) u_rem0 (.clock_i(clock_i),
    .line_i(txd_o[0]), .line_o(rxd_i[0]));
  dcut_remote #(.TXB(5208), .RXB(2604), .NB(6)) u_rem1 (.clock_i(clock_i),
    .line_i(txd_o[1]), .line_o(rxd_i[1]));
  // 100 MHz clock
  always #5 clock_i = ~clock_i;
  // one apb transfer; waits for pready, releases after the sampling edge
  task xfer(input w, input [7:0] a, input [31:0] d);
    begin
      psel_i <= 1'b1;
      pwrite_i <= w;
      paddr_i <= a;
      pwdata_i <= d;
      @(posedge clock_i);
      penable_i <= 1'b1;
      @(posedge clock_i);
      // no own limit: only the watchdog ends a hung wait
      while (pready_o !== 1'b1)
        @(posedge clock_i);
      rdata = prdata_o;
      rerr = pslverr_o;
      psel_i <= 1'b0;
      penable_i <= 1'b0;
      @(posedge clock_i);
    end
  endtask
  task check(input [31:0] seen, input [31:0] exp);
    begin
      comparisons = comparisons + 1;
      if (seen !== exp)
      begin
        mismatches = mismatches + 1;
        $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
    end
  endtask
  task conclude;
    begin
      $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  // hang guard: the run needs some 45000 cycles
  initial
  begin
    repeat (80000) @(posedge clock_i);
    mismatches = mismatches + 1;
    conclude;
  end
  // main sequence
  initial
  begin
    repeat (6) @(posedge clock_i);
    nrst_i <= 1'b1;
    @(posedge clock_i);
    check({27'h0, txd_o, rts_o, irq_o}, 32'h18);
    xfer(1'b0, `DCUT_OFS_TPRE, 32'h0);
    check(rdata, 32'hFFFF);
    xfer(1'b0, `DCUT_OFS_STAT0, 32'h0);
    check(rdata, 32'h20);
    xfer(1'b0, 8'h3C, 32'h0);
    check({31'h0, rerr}, 32'h1);
    check(rdata, 32'h0);
    for (i = 0; i < 4; i = i + 1)
    begin
      xfer(1'b1, `DCUT_OFS_MODE0, i << 9);
      xfer(1'b0, `DCUT_OFS_MODE0, 32'h0);
      check(rdata, i << 9);
    end
    $display("test registers done");
    // ch0 8 bits even; ch1 5 bits odd, rx 19200, cts gated, rts on
    xfer(1'b1, `DCUT_OFS_MODE0, 32'h010000F7);
    xfer(1'b1, `DCUT_OFS_MODE1, 32'h01B010F8);
    check({30'h0, rts_o}, 32'h2);
    xfer(1'b1, `DCUT_OFS_IEN, 32'h141);
    xfer(1'b1, `DCUT_OFS_DATA1, 32'h15);
    xfer(1'b1, `DCUT_OFS_DATA1, 32'h0C);
    xfer(1'b1, `DCUT_OFS_DATA1, 32'h1F);
    xfer(1'b0, `DCUT_OFS_STAT1, 32'h0);
    check(rdata[4:3], 32'h2);
    repeat (300) @(posedge clock_i);
    check(txd_o[1], 32'h1);
    cts_i <= 2'h2;
    fork
      u_rem0.send({^8'hA6, 8'hA6}, 9);
      u_rem1.send({^5'h0B, 5'h0B}, 6); // parity bit wrong for odd
      begin
        n = 0;
        while (u_rem1.got_n < 2 && n < 60000)
        begin
          n = n + 1;
          @(posedge clock_i);
        end
      end
    join
    // second character's stop ends after the remote frame; let it pass
    repeat (600) @(posedge clock_i);
    check(u_rem1.got[0], {1'b1, ~^5'h15, 5'h15});
    check(u_rem1.got[1], {1'b1, ~^5'h0C, 5'h0C});
    check(u_rem1.got_n, 32'h2);
    xfer(1'b0, `DCUT_OFS_ISTAT, 32'h0);
    check(rdata, 32'h161);
    check(irq_o, 32'h1);
    xfer(1'b0, `DCUT_OFS_DATA0, 32'h0);
    check(rdata[8:0], 32'hA6);
    xfer(1'b0, `DCUT_OFS_DATA1, 32'h0);
    check(rdata[4:0], 32'h0B);
    check(txd_o[0], 32'h1);
    xfer(1'b1, `DCUT_OFS_IEN, 32'h0);
    check(irq_o, 32'h0);
    xfer(1'b1, `DCUT_OFS_IEN, 32'h141);
    xfer(1'b1, `DCUT_OFS_ICLR, 32'h7FF);
    xfer(1'b0, `DCUT_OFS_ISTAT, 32'h0);
    check({rdata[30:0], irq_o}, 32'h0);
    $display("test serial done");
    // counter mode: one zero event, then run clears
    xfer(1'b1, `DCUT_OFS_TPRE, 32'h14);
    xfer(1'b1, `DCUT_OFS_TCTL, 32'h2);
    repeat (1000) @(posedge clock_i);
    xfer(1'b0, `DCUT_OFS_ISTAT, 32'h0);
    check(rdata, 32'h400);
    xfer(1'b0, `DCUT_OFS_TCTL, 32'h0);
    check(rdata[1], 32'h0);
    xfer(1'b0, `DCUT_OFS_TCNT, 32'h0);
    check(rdata, 32'h14);
    xfer(1'b1, `DCUT_OFS_ICLR, 32'h400);
    repeat (1000) @(posedge clock_i);
    xfer(1'b0, `DCUT_OFS_ISTAT, 32'h0);
    check(rdata, 32'h0);
    // timer mode: half duty square, periodic zero events
    xfer(1'b1, `DCUT_OFS_TPRE, 32'h3);
    xfer(1'b1, `DCUT_OFS_TDUTY, 32'h2);
    xfer(1'b1, `DCUT_OFS_TCTL, 32'h3);
    i = 0;
    repeat (400)
    begin
      @(posedge clock_i);
      if (tmr_sq_o === 1'b1)
        i = i + 1;
    end
    check(i > 100 && i < 300, 32'h1);
    xfer(1'b1, `DCUT_OFS_ICLR, 32'h400);
    repeat (300) @(posedge clock_i);
    xfer(1'b0, `DCUT_OFS_ISTAT, 32'h0);
    check(rdata, 32'h400);
    xfer(1'b1, `DCUT_OFS_TCTL, 32'h0);
    // give the stop check time to see the square output fall
    repeat (4) @(posedge clock_i);
    check(tmr_sq_o, 32'h0);
    $display("test timer done");
    conclude;
  end
endmodule // dcut_top_test
